//--- design/dts_pkg.sv
// package for the debug trigger sequencer: offsets, fields, state codes
package dts_pkg;
	// register offsets (byte addresses on the plain port)
	localparam logic [7:0] DTS_OFF_COUNT = 8'h26;
	localparam logic [7:0] DTS_OFF_SCR = 8'h27;
	localparam logic [7:0] DTS_OFF_CTL = 8'h28;
	localparam logic [7:0] DTS_OFF_ADDRH = 8'h29;
	localparam logic [7:0] DTS_OFF_ADDRM = 8'h2a;
	localparam logic [7:0] DTS_OFF_ADDRL = 8'h2b;
	localparam logic [7:0] DTS_OFF_DBGCTL = 8'h20;
	// field positions
	localparam int DTS_CTL_ENABLE_BIT = 0;
	localparam int DTS_DBG_ARM_BIT = 7;
	localparam int DTS_DBG_VIEW_LSB = 0;
	localparam int DTS_ADDRH_BITS = 2;
	// reset values
	localparam logic [7:0] DTS_RST_BYTE = 8'h00;
	localparam logic [1:0] DTS_VIEW_SCR = 2'h0;
	localparam logic [3:0] DTS_SC_RESET = 4'h0;
	// sequencer states, gray along State1 -> State2 -> State3 -> Final
	typedef enum logic [1:0] {
		DTS_ST_STATE1 = 2'b00,
		DTS_ST_STATE2 = 2'b01,
		DTS_ST_STATE3 = 2'b11,
		DTS_ST_FINAL = 2'b10
	} dts_state_t;
	// one register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} dts_req_t;
endpackage

//--- design/dts_regbank.sv
// small register memory holding the three comparator control bytes
`timescale 1ns/1ps
module dts_regbank #(
	parameter int DEPTH = 3,
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// write side
	input wire logic we,
	input wire logic [1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	// read side, data registered
	input wire logic [1:0] raddr,
	output logic [WIDTH-1:0] rdata,
	// all entries flat, for enable bits
	output logic [DEPTH*WIDTH-1:0] flat
);
	// two address bits reach at most four entries
	if (DEPTH < 1 || DEPTH > 4) begin : g_depth_check
		$error("dts_regbank depth out of range");
	end
	logic [WIDTH-1:0] mem_reg [DEPTH];
	// storage, cleared on reset
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
		end else if (we && int'(waddr) < DEPTH) begin
			mem_reg[waddr] <= wdata;
		end
	end
	// registered read port
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdata <= '0;
		end else begin
			rdata <= (int'(raddr) < DEPTH) ? mem_reg[raddr] : '0;
		end
	end
	always_comb begin
		for (int i = 0; i < DEPTH; i++) flat[i*WIDTH +: WIDTH] = mem_reg[i];
	end
endmodule

//--- design/dts_sequencer.sv
// state1 transition logic and comparator register window of the debug sequencer
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module dts_sequencer #(
	parameter int NUM_CMP = 3
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// register port
	input wire dts_pkg::dts_req_t bus_req,
	output logic [7:0] bus_rdata,
	// comparator raw match events
	input wire logic [NUM_CMP-1:0] cmp_hit,
	// state and external reset of the sequence
	input wire logic seq_restart,
	output dts_pkg::dts_state_t seq_state,
	output logic [NUM_CMP-1:0] match_flags
);
	import dts_pkg::*;

	// the select decode below is written for exactly three channels
	if (NUM_CMP != 3) begin : g_cmp_check
		$error("dts_sequencer serves exactly three comparators");
	end

	// =====================================================
	// registers
	logic armed_reg;
	logic [1:0] view_reg;
	logic [3:0] sc_reg;
	logic [1:0] addrh_reg;
	logic [7:0] addrm_reg;
	logic [7:0] addrl_reg;
	logic [7:0] count_reg;
	logic [NUM_CMP-1:0] mflag_reg;
	dts_state_t state_reg;
	dts_state_t state_next;
	logic [7:0] ctl_rdata;
	logic [NUM_CMP*8-1:0] ctl_flat;
	logic [NUM_CMP-1:0] match;
	logic sel_reg_q;
	logic [7:0] rd_direct_reg;

	// view selector decodes which comparator control is at the shared offset
	function automatic logic [1:0] view_index(input logic [1:0] v);
		return (v == 2'h3) ? 2'h2 : v;
	endfunction

	wire hit_ctl = (bus_req.addr == DTS_OFF_CTL);
	wire scr_visible = (view_reg == DTS_VIEW_SCR);

	// comparator control bytes in their own memory; view picks the slot
	dts_regbank #(.DEPTH(NUM_CMP), .WIDTH(8)) u_ctl (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.we(bus_req.wr && hit_ctl && !armed_reg),
		.waddr(view_index(view_reg)),
		.wdata(bus_req.wdata),
		.raddr(view_index(view_reg)),
		.rdata(ctl_rdata),
		.flat(ctl_flat)
	);

	// matches only count from enabled comparators
	always_comb begin
		for (int i = 0; i < NUM_CMP; i++) begin
			match[i] = cmp_hit[i] && ctl_flat[i*8 + DTS_CTL_ENABLE_BIT];
		end
	end

	// =====================================================
	// control register: arm bit and view selector
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			armed_reg <= 1'b0;
			view_reg <= DTS_VIEW_SCR;
		end else if (bus_req.wr && bus_req.addr == DTS_OFF_DBGCTL) begin
			armed_reg <= bus_req.wdata[DTS_DBG_ARM_BIT];
			view_reg <= bus_req.wdata[DTS_DBG_VIEW_LSB +: 2];
		end
	end

	// state1 select code; locked while armed or another view is shown
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sc_reg <= DTS_SC_RESET;
		end else if (bus_req.wr && bus_req.addr == DTS_OFF_SCR && scr_visible && !armed_reg) begin
			sc_reg <= bus_req.wdata[3:0];
		end
	end

	// comparator address, writable only while disarmed
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			addrh_reg <= '0;
			addrm_reg <= DTS_RST_BYTE;
			addrl_reg <= DTS_RST_BYTE;
		end else if (bus_req.wr && !armed_reg) begin
			if (bus_req.addr == DTS_OFF_ADDRH) addrh_reg <= bus_req.wdata[DTS_ADDRH_BITS-1:0];
			if (bus_req.addr == DTS_OFF_ADDRM) addrm_reg <= bus_req.wdata;
			if (bus_req.addr == DTS_OFF_ADDRL) addrl_reg <= bus_req.wdata;
		end
	end

	// =====================================================
	// next state from State1; final-bound matches win, then low channel
	always_comb begin
		state_next = state_reg;
		if (state_reg == DTS_ST_STATE1) begin
			case (sc_reg)
				4'h0: if (|match) state_next = DTS_ST_FINAL;
				4'h1: if (match[1]) state_next = DTS_ST_STATE3;
				4'h2: if (match[2]) state_next = DTS_ST_STATE2;
				4'h3: if (match[1]) state_next = DTS_ST_STATE2;
				4'h4: begin
					// lower channel wins
					if (match[0]) state_next = DTS_ST_STATE2;
					else if (match[1]) state_next = DTS_ST_STATE3;
				end
				4'h5: begin
					if (match[0]) state_next = DTS_ST_FINAL;
					else if (match[1]) state_next = DTS_ST_STATE3;
				end
				4'h6: begin
					if (match[0]) state_next = DTS_ST_STATE2;
					else if (match[2]) state_next = DTS_ST_STATE3;
				end
				4'h7: if (match[0] || match[1]) state_next = DTS_ST_STATE2;
				4'h9: if (match[0]) state_next = DTS_ST_STATE3;
				4'hd: begin
					if (match[0] || match[2]) state_next = DTS_ST_FINAL;
					else if (match[1]) state_next = DTS_ST_STATE2;
				end
				default: state_next = state_reg;
			endcase
		end
	end

	// sequencer steps only while armed; disarm returns to State1
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_reg <= DTS_ST_STATE1;
		end else if (!armed_reg || seq_restart) begin
			state_reg <= DTS_ST_STATE1;
		end else begin
			state_reg <= state_next;
		end
	end

	// sticky match flags while armed, loaded with current matches on any control write while disarmed
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			mflag_reg <= '0;
		end else if (armed_reg) begin
			mflag_reg <= mflag_reg | match;
		end else if (bus_req.wr && bus_req.addr == DTS_OFF_DBGCTL) begin
			mflag_reg <= match;
		end
	end

	// count of state1 transitions taken, saturating
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			count_reg <= DTS_RST_BYTE;
		end else if (armed_reg && !seq_restart && state_next != state_reg
			&& count_reg != 8'hff) begin
			count_reg <= count_reg + 8'h01;
		end
	end

	// =====================================================
	// read path, one cycle later; shared offset depends on view
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rd_direct_reg <= DTS_RST_BYTE;
			sel_reg_q <= 1'b0;
		end else begin
			sel_reg_q <= bus_req.rd && hit_ctl;
			rd_direct_reg <= DTS_RST_BYTE;
			if (bus_req.rd) begin
				case (bus_req.addr)
					DTS_OFF_DBGCTL: rd_direct_reg <= {armed_reg, 5'h00, view_reg};
					DTS_OFF_COUNT: rd_direct_reg <= count_reg;
					DTS_OFF_SCR: rd_direct_reg <= scr_visible ? {4'h0, sc_reg}
						: {5'h00, mflag_reg};
					DTS_OFF_ADDRH: rd_direct_reg <= {6'h00, addrh_reg};
					DTS_OFF_ADDRM: rd_direct_reg <= addrm_reg;
					DTS_OFF_ADDRL: rd_direct_reg <= addrl_reg;
					default: rd_direct_reg <= DTS_RST_BYTE;
				endcase
			end
		end
	end

	assign bus_rdata = sel_reg_q ? ctl_rdata : rd_direct_reg;
	assign seq_state = state_reg;
	assign match_flags = mflag_reg;

	// =====================================================
	// checks
	property p_lock;
		@(posedge clk_sys) disable iff (!rstn)
		armed_reg |=> $stable(sc_reg);
	endproperty
	a_lock: assert property (p_lock) else $error("select code changed while armed");

	property p_idle;
		@(posedge clk_sys) disable iff (!rstn)
		!armed_reg |=> state_reg == DTS_ST_STATE1;
	endproperty
	a_idle: assert property (p_idle) else $error("state moved while disarmed");

	property p_any_final;
		@(posedge clk_sys) disable iff (!rstn)
		armed_reg && !seq_restart && state_reg == DTS_ST_STATE1 && sc_reg == 4'h0 && |match
		|=> state_reg == DTS_ST_FINAL;
	endproperty
	a_any_final: assert property (p_any_final) else $error("code 0 missed final");

	property p_rsv;
		@(posedge clk_sys) disable iff (!rstn)
		state_reg == DTS_ST_STATE1 && (sc_reg == 4'h8 || sc_reg >= 4'ha && sc_reg != 4'hd)
		|=> state_reg == DTS_ST_STATE1;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved code moved state");

	property p_prio;
		@(posedge clk_sys) disable iff (!rstn)
		armed_reg && !seq_restart && state_reg == DTS_ST_STATE1 && sc_reg == 4'hd
		&& match[0] && match[1] |=> state_reg == DTS_ST_FINAL;
	endproperty
	a_prio: assert property (p_prio) else $error("final priority lost");

	property p_c4;
		@(posedge clk_sys) disable iff (!rstn)
		armed_reg && !seq_restart && state_reg == DTS_ST_STATE1 && sc_reg == 4'h4
		&& !match[0] && match[1] |=> state_reg == DTS_ST_STATE3;
	endproperty
	a_c4: assert property (p_c4) else $error("code 4 match1 wrong");

	property p_c7;
		@(posedge clk_sys) disable iff (!rstn)
		armed_reg && !seq_restart && state_reg == DTS_ST_STATE1 && sc_reg == 4'h7
		&& match[1] |=> state_reg == DTS_ST_STATE2;
	endproperty
	a_c7: assert property (p_c7) else $error("code 7 wrong");

	property p_unnamed;
		@(posedge clk_sys) disable iff (!rstn)
		armed_reg && !seq_restart && state_reg == DTS_ST_STATE1 && sc_reg == 4'h2
		&& !match[2] |=> state_reg == DTS_ST_STATE1;
	endproperty
	a_unnamed: assert property (p_unnamed) else $error("unnamed match moved state");

	property p_c5;
		@(posedge clk_sys) disable iff (!rstn)
		armed_reg && !seq_restart && state_reg == DTS_ST_STATE1 && sc_reg == 4'h5
		&& match[0] |=> state_reg == DTS_ST_FINAL;
	endproperty
	a_c5: assert property (p_c5) else $error("code 5 match0 missed final");

	property p_c6;
		@(posedge clk_sys) disable iff (!rstn)
		armed_reg && !seq_restart && state_reg == DTS_ST_STATE1 && sc_reg == 4'h6
		&& !match[0] && match[2] |=> state_reg == DTS_ST_STATE3;
	endproperty
	a_c6: assert property (p_c6) else $error("code 6 match2 wrong");

	property p_c9;
		@(posedge clk_sys) disable iff (!rstn)
		armed_reg && !seq_restart && state_reg == DTS_ST_STATE1 && sc_reg == 4'h9
		&& match[0] |=> state_reg == DTS_ST_STATE3;
	endproperty
	a_c9: assert property (p_c9) else $error("code 9 match0 wrong");

	property p_cd;
		@(posedge clk_sys) disable iff (!rstn)
		armed_reg && !seq_restart && state_reg == DTS_ST_STATE1 && sc_reg == 4'hd
		&& !match[0] && !match[2] && match[1] |=> state_reg == DTS_ST_STATE2;
	endproperty
	a_cd: assert property (p_cd) else $error("code 13 match1 wrong");

	// other views hide the select code, so writes there must not land
	property p_view_lock;
		@(posedge clk_sys) disable iff (!rstn)
		!scr_visible |=> $stable(sc_reg);
	endproperty
	a_view_lock: assert property (p_view_lock) else $error("select code written in other view");

	// a read of the shared offset: select code in view zero, match flags otherwise
	sequence s_scr_read;
		bus_req.rd && bus_req.addr == DTS_OFF_SCR && scr_visible;
	endsequence
	sequence s_flag_read;
		bus_req.rd && bus_req.addr == DTS_OFF_SCR && !scr_visible;
	endsequence
	property p_scr_view;
		@(posedge clk_sys) disable iff (!rstn)
		s_scr_read |=> bus_rdata == {4'h0, $past(sc_reg)};
	endproperty
	a_scr_view: assert property (p_scr_view) else $error("view zero read wrong");

	property p_flag_view;
		@(posedge clk_sys) disable iff (!rstn)
		s_flag_read |=> bus_rdata == {5'h00, $past(mflag_reg)};
	endproperty
	a_flag_view: assert property (p_flag_view) else $error("flag view read wrong");
endmodule

//--- verification/debug_trigger_sequencer_tb_top.sv
// self-checking bench for the state1 transition logic and its register window
`timescale 1ns/1ps
module debug_trigger_sequencer_tb_top;
	import dts_pkg::*;
	// ========================================
	// signals and device under test
	logic clk_sys;
	logic rstn;
	dts_req_t bus_req;
	logic [7:0] bus_rdata;
	logic [2:0] cmp_hit;
	logic seq_restart;
	dts_state_t seq_state;
	logic [2:0] match_flags;
	int fails;
	int tests_run;
	logic [7:0] rdv;
	logic [3:0] kept;
	int moves;
	logic [17:0] addr_v;

	dts_sequencer #(.NUM_CMP(3)) DUT (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.bus_req(bus_req),
		.bus_rdata(bus_rdata),
		.cmp_hit(cmp_hit),
		.seq_restart(seq_restart),
		.seq_state(seq_state),
		.match_flags(match_flags)
	);

	// ========================================
	// expectations
	// per channel {ch2,ch1,ch0}: 0 none, 1 State2, 2 State3, 3 Final
	function automatic logic [5:0] targets(input logic [3:0] sc);
		case (sc)
			4'h0: return 6'b11_11_11;
			4'h1: return 6'b00_10_00;
			4'h2: return 6'b01_00_00;
			4'h3: return 6'b00_01_00;
			4'h4: return 6'b00_10_01;
			4'h5: return 6'b00_10_11;
			4'h6: return 6'b10_00_01;
			4'h7: return 6'b00_01_01;
			4'h9: return 6'b00_00_10;
			4'hd: return 6'b11_01_11;
			default: return 6'b00_00_00;
		endcase
	endfunction

	// final wins, otherwise lowest channel that names a target
	function automatic dts_state_t exp_state(input logic [3:0] sc, input logic [2:0] hit);
		logic [5:0] t;
		logic [1:0] best;
		t = targets(sc);
		best = 2'd0;
		for (int ch = 0; ch < 3; ch++) begin
			if (hit[ch] && t[2*ch +: 2] == 2'd3)
				return DTS_ST_FINAL;
			if (hit[ch] && best == 2'd0)
				best = t[2*ch +: 2];
		end
		if (best == 2'd1)
			return DTS_ST_STATE2;
		if (best == 2'd2)
			return DTS_ST_STATE3;
		return DTS_ST_STATE1;
	endfunction

	// ========================================
	// bus and compare tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys) bus_req <= '0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys) bus_req <= '0;
		#1 d = bus_rdata;
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_state(input dts_state_t exp);
		tests_run++;
		if (seq_state !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, seq_state, exp);
		end
	endtask

	task automatic chk_flags(input logic [2:0] exp);
		tests_run++;
		if (match_flags !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, match_flags, exp);
		end
	endtask

	// one-cycle match pulse, state looked at after the sampling edge
	task automatic pulse(input logic [2:0] h, input dts_state_t exp);
		@(posedge clk_sys) cmp_hit <= h;
		@(posedge clk_sys) cmp_hit <= 3'b000;
		#1 chk_state(exp);
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ========================================
	// clock, reset, watchdog
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// whole run is about 1200 cycles; allow about sixteen times that
	initial begin
		#(20000 * 8);
		fails++;
		complete_run;
	end

	// ========================================
	// main sequence
	initial begin
		rstn = 1'b0;
		bus_req = '0;
		cmp_hit = 3'b000;
		seq_restart = 1'b0;
		fails = 0;
		tests_run = 0;
		moves = 0;
		void'($urandom(18));
		repeat (5) @(posedge clk_sys);
		rstn <= 1'b1;
		#1 chk_state(DTS_ST_STATE1);
		// enable all three comparators, one per view
		for (int v = 0; v < 3; v++) begin
			wr(DTS_OFF_DBGCTL, 8'(v));
			wr(DTS_OFF_CTL, 8'h01);
			rd(DTS_OFF_CTL, rdv);
			chk_byte(rdv, 8'h01);
		end
		rd(8'h3f, rdv);
		chk_byte(rdv, 8'h00);
		// every select code against every nonzero match pattern
		for (int c = 0; c < 16; c++) begin
			for (int h = 1; h < 8; h++) begin
				wr(DTS_OFF_DBGCTL, 8'h00);
				wr(DTS_OFF_SCR, {4'($urandom), 4'(c)});
				rd(DTS_OFF_SCR, rdv);
				chk_byte(rdv, {4'h0, 4'(c)});
				wr(DTS_OFF_DBGCTL, 8'h80);
				pulse(3'(h), exp_state(4'(c), 3'(h)));
				chk_flags(3'(h));
				if (exp_state(4'(c), 3'(h)) != DTS_ST_STATE1)
					moves++;
			end
		end
		// one count per state1 transition taken in the sweep
		rd(DTS_OFF_COUNT, rdv);
		chk_byte(rdv, 8'(moves));
		// writes refused while armed and while another view is selected
		kept = 4'hf; // last code of the sweep
		wr(DTS_OFF_SCR, 8'h05);
		wr(DTS_OFF_DBGCTL, 8'h01);
		wr(DTS_OFF_SCR, 8'h0a);
		wr(DTS_OFF_DBGCTL, 8'h00);
		rd(DTS_OFF_SCR, rdv);
		chk_byte(rdv, {4'h0, kept});
		// comparator address, 18 bits over three byte offsets
		addr_v = 18'($urandom);
		wr(DTS_OFF_ADDRH, {6'($urandom), addr_v[17:16]});
		wr(DTS_OFF_ADDRM, addr_v[15:8]);
		wr(DTS_OFF_ADDRL, addr_v[7:0]);
		rd(DTS_OFF_ADDRH, rdv);
		chk_byte(rdv, {6'h00, addr_v[17:16]});
		rd(DTS_OFF_ADDRM, rdv);
		chk_byte(rdv, addr_v[15:8]);
		rd(DTS_OFF_ADDRL, rdv);
		chk_byte(rdv, addr_v[7:0]);
		// disarmed: matches leave State1 alone
		wr(DTS_OFF_SCR, 8'h00);
		pulse(3'b111, DTS_ST_STATE1);
		// comparator 0 disabled: its matches do nothing; address locked while armed
		wr(DTS_OFF_CTL, 8'h00);
		wr(DTS_OFF_DBGCTL, 8'h80);
		wr(DTS_OFF_ADDRL, ~addr_v[7:0]);
		pulse(3'b001, DTS_ST_STATE1);
		chk_flags(3'b000);
		pulse(3'b010, DTS_ST_FINAL);
		chk_flags(3'b010);
		rd(DTS_OFF_ADDRL, rdv);
		chk_byte(rdv, addr_v[7:0]);
		// view one shows the match flags at the shared offset
		wr(DTS_OFF_DBGCTL, 8'h81);
		rd(DTS_OFF_SCR, rdv);
		chk_byte(rdv, 8'h02);
		// restart input brings the sequence back to State1
		@(posedge clk_sys) seq_restart <= 1'b1;
		@(posedge clk_sys) seq_restart <= 1'b0;
		#1 chk_state(DTS_ST_STATE1);
		// reset in mid-run: state, flags, count and low address byte back to reset values
		pulse(3'b010, DTS_ST_FINAL);
		@(posedge clk_sys) rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		#1 chk_state(DTS_ST_STATE1);
		chk_flags(3'b000);
		rd(DTS_OFF_COUNT, rdv);
		chk_byte(rdv, DTS_RST_BYTE);
		rd(DTS_OFF_ADDRL, rdv);
		chk_byte(rdv, DTS_RST_BYTE);
		complete_run;
	end
endmodule
